// ### logic/ipf_pkg.sv
// Purpose: Shared constants, types and helpers for the interrupt priority fields.
// Assumes: Avalon-MM slave with 32-bit data; register index times four is the byte address.
// Notes: Sixteen-bit registers sit in the low half of each word.
package ipf_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_W = 16;
    localparam int unsigned FIELD_W = 2;
    localparam int unsigned NUM_SRC = 22;
    localparam int unsigned ADDR_LSB = 2;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_TIMERS_A_TWOWIRE = 6'h04;
    localparam logic [5:0] IDX_INTERVAL_COMPARE_TIMERS_B = 6'h05;
    localparam logic [5:0] IDX_PWM_CONVERTER = 6'h06;
    localparam logic [5:0] IDX_FORWARDED = 6'h10;
    localparam logic [5:0] IDX_TOP_LEVEL = 6'h11;

    // ----------------------------------------------------------------
    // Reset values and write masks
    // ----------------------------------------------------------------
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    localparam logic [15:0] FULL_WMASK = 16'hFFFF;
    localparam logic [15:0] PWM_CONVERTER_WMASK = 16'h0FFF;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions (low bit of each two-bit field)
    // ----------------------------------------------------------------
    localparam int unsigned FIRST_TIMER_CH3_LSB = 14;
    localparam int unsigned FIRST_TIMER_CH2_LSB = 12;
    localparam int unsigned FIRST_TIMER_CH1_LSB = 10;
    localparam int unsigned FIRST_TIMER_CH0_LSB = 8;
    localparam int unsigned TWOWIRE_STATUS_LSB = 6;
    localparam int unsigned TWOWIRE_TRANSMIT_LSB = 4;
    localparam int unsigned TWOWIRE_RECEIVE_LSB = 2;
    localparam int unsigned TWOWIRE_GENERAL_CALL_LSB = 0;
    localparam int unsigned INTERVAL_TIMER1_LSB = 14;
    localparam int unsigned INTERVAL_TIMER0_LSB = 12;
    localparam int unsigned SECOND_COMPARATOR_LSB = 10;
    localparam int unsigned FIRST_COMPARATOR_LSB = 8;
    localparam int unsigned SECOND_TIMER_CH3_LSB = 6;
    localparam int unsigned SECOND_TIMER_CH2_LSB = 4;
    localparam int unsigned SECOND_TIMER_CH1_LSB = 2;
    localparam int unsigned SECOND_TIMER_CH0_LSB = 0;
    localparam int unsigned PWM_FAULT_LSB = 10;
    localparam int unsigned PWM_RELOAD_LSB = 8;
    localparam int unsigned CONVERTER_ZERO_CROSS_LSB = 6;
    localparam int unsigned CONVERTER_B_DONE_LSB = 4;
    localparam int unsigned CONVERTER_A_DONE_LSB = 2;
    localparam int unsigned INTERVAL_TIMER2_LSB = 0;

    // ----------------------------------------------------------------
    // Level codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_0 = 2'h1;
    localparam logic [1:0] LVL_1 = 2'h2;
    localparam logic [1:0] LVL_2 = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SRC-1:0] lvl2;
        logic [NUM_SRC-1:0] lvl1;
        logic [NUM_SRC-1:0] lvl0;
    } ipf_lvl_req_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] index;
        logic [DATA_W-1:0] wdata;
        logic [3:0] be;
    } ipf_bus_req_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } ipf_bus_state_e;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Turns a field code into one bit per level, bit 2 for level 2.
    function automatic logic [2:0] ipf_level_onehot(input logic [1:0] code);
        logic [2:0] res;
        res = 3'h0;
        case (code)
            LVL_0: res = 3'h1;
            LVL_1: res = 3'h2;
            LVL_2: res = 3'h4;
            default: res = 3'h0;
        endcase
        return res;
    endfunction

    // Merges a byte-enabled write into a sixteen-bit register.
    function automatic logic [15:0] ipf_merge(input logic [15:0] old, input logic [31:0] wdata,
                                              input logic [3:0] be, input logic [15:0] wmask);
        logic [15:0] upd;
        upd = old;
        if (be[0]) begin
            upd[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            upd[15:8] = wdata[15:8];
        end
        return upd & wmask;
    endfunction

endpackage

// ### logic/ipf_level_gate.sv
// Purpose: Sorts pending source requests onto the three priority levels.
// Assumes: Fields and requests come from the same clock; purely combinational.
// Notes: Source n uses field bits 2n+1:2n of the packed field vector.
`timescale 1ns/1ns
module ipf_level_gate #(
    parameter int unsigned NSRC = ipf_pkg::NUM_SRC
) (
    // Configuration
    input wire logic [2*NSRC-1:0] fields,
    // Requests
    input wire logic [NSRC-1:0] src_req,
    // Sorted requests
    output ipf_pkg::ipf_lvl_req_s lvl_req
);

    // ----------------------------------------------------------------
    // Per-source decode
    // ----------------------------------------------------------------
    logic [2:0] onehot [NSRC];

    for (genvar n = 0; n < NSRC; n++) begin : g_src
        assign onehot[n] = ipf_pkg::ipf_level_onehot(fields[2*n +: 2]); // [RULE_01]
        assign lvl_req.lvl0[n] = src_req[n] & onehot[n][0]; // [RULE_12]
        assign lvl_req.lvl1[n] = src_req[n] & onehot[n][1]; // [RULE_12]
        assign lvl_req.lvl2[n] = src_req[n] & onehot[n][2]; // [RULE_12]
    end

endmodule

// ### logic/ipf_priority_regs.sv
// Purpose: Priority field registers for 22 sources and the level gating they steer.
// Assumes: Avalon-MM master on clk_sys; source requests are levels on clk_sys.
// Notes: Requests and summary outputs are registered, one cycle behind the inputs.
//
// Summary of operation
// [RULE_01] Field codes: off, level 0, 1, 2.
// [RULE_02] All priority fields reset to zero.
// [RULE_03] First timer channels 3..0 at bits 15:8.
// [RULE_04] Two-wire status, transmit, receive, call at 7:0.
// [RULE_05] Interval timers 1 and 0 at 15:12.
// [RULE_06] Second, first comparator at bits 11:8.
// [RULE_07] Second timer channels 3..0 at bits 7:0.
// [RULE_08] Third register bits 15:12 reserved, read zero.
// [RULE_09] PWM fault level at bits 11:10.
// [RULE_10] PWM reload level at bits 9:8.
// [RULE_11] Converter and interval timer 2 at 7:0.
// [RULE_12] Only nonzero fields forward pending requests.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module ipf_priority_regs #(
    parameter int unsigned NSRC = ipf_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [ipf_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ipf_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ipf_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Source requests
    input wire logic [NSRC-1:0] src_req,
    // Requests toward the core
    output ipf_pkg::ipf_lvl_req_s core_req,
    output logic [1:0] core_top_level,
    output logic core_any_req
);

    // ----------------------------------------------------------------
    // Bus request capture
    // ----------------------------------------------------------------
    // One access at a time.
    ipf_pkg::ipf_bus_req_s bus;
    ipf_pkg::ipf_bus_state_e state_q;
    ipf_pkg::ipf_bus_state_e state_d;
    logic bus_req;
    logic bus_take;
    logic bus_wr;

    assign bus.read = avs_read;
    assign bus.write = avs_write;
    assign bus.index = avs_address[ipf_pkg::ADDR_W-1:ipf_pkg::ADDR_LSB];
    assign bus.wdata = avs_writedata;
    assign bus.be = avs_byteenable;
    assign bus_req = bus.read | bus.write;
    assign bus_take = bus_req & (state_q == ipf_pkg::BUS_IDLE);
    assign bus_wr = bus_take & bus.write;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Unmapped indices read zero.
    logic sel_timers_a;
    logic sel_interval;
    logic sel_pwm_conv;
    logic sel_forwarded;
    logic sel_top_level;

    assign sel_timers_a = bus.index == ipf_pkg::IDX_TIMERS_A_TWOWIRE;
    assign sel_interval = bus.index == ipf_pkg::IDX_INTERVAL_COMPARE_TIMERS_B;
    assign sel_pwm_conv = bus.index == ipf_pkg::IDX_PWM_CONVERTER;
    assign sel_forwarded = bus.index == ipf_pkg::IDX_FORWARDED;
    assign sel_top_level = bus.index == ipf_pkg::IDX_TOP_LEVEL;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Each access waits one cycle.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ipf_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    state_d = ipf_pkg::BUS_DONE;
                end
            end
            ipf_pkg::BUS_DONE: state_d = ipf_pkg::BUS_IDLE;
            default: state_d = ipf_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ipf_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            state_q <= state_d;
            avs_waitrequest <= state_d != ipf_pkg::BUS_DONE;
        end
    end

    // ----------------------------------------------------------------
    // Priority registers
    // ----------------------------------------------------------------
    logic [15:0] prio_timers_a_q;
    logic [15:0] prio_timers_a_d;
    logic [15:0] prio_interval_q;
    logic [15:0] prio_interval_d;
    logic [15:0] prio_pwm_conv_q;
    logic [15:0] prio_pwm_conv_d;

    assign prio_timers_a_d = (bus_wr && sel_timers_a) ?
        ipf_pkg::ipf_merge(prio_timers_a_q, bus.wdata, bus.be, ipf_pkg::FULL_WMASK) :
        prio_timers_a_q;
    assign prio_interval_d = (bus_wr && sel_interval) ?
        ipf_pkg::ipf_merge(prio_interval_q, bus.wdata, bus.be, ipf_pkg::FULL_WMASK) :
        prio_interval_q;
    // Reserved top nibble is never stored, so it reads back as zero.
    assign prio_pwm_conv_d = (bus_wr && sel_pwm_conv) ?
        ipf_pkg::ipf_merge(prio_pwm_conv_q, bus.wdata, bus.be,
                           ipf_pkg::PWM_CONVERTER_WMASK) : // [RULE_08]
        prio_pwm_conv_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prio_timers_a_q <= ipf_pkg::PRIO_RESET; // [RULE_02]
            prio_interval_q <= ipf_pkg::PRIO_RESET; // [RULE_02]
            prio_pwm_conv_q <= ipf_pkg::PRIO_RESET; // [RULE_02]
        end else begin
            prio_timers_a_q <= prio_timers_a_d;
            prio_interval_q <= prio_interval_d;
            prio_pwm_conv_q <= prio_pwm_conv_d;
        end
    end

    // ----------------------------------------------------------------
    // Named fields
    // ----------------------------------------------------------------
    logic [1:0] first_timer_ch3_level;
    logic [1:0] first_timer_ch2_level;
    logic [1:0] first_timer_ch1_level;
    logic [1:0] first_timer_ch0_level;
    logic [1:0] twowire_status_level;
    logic [1:0] twowire_transmit_level;
    logic [1:0] twowire_receive_level;
    logic [1:0] twowire_general_call_level;
    logic [1:0] interval_timer1_level;
    logic [1:0] interval_timer0_level;
    logic [1:0] second_comparator_level;
    logic [1:0] first_comparator_level;
    logic [1:0] second_timer_ch3_level;
    logic [1:0] second_timer_ch2_level;
    logic [1:0] second_timer_ch1_level;
    logic [1:0] second_timer_ch0_level;
    logic [1:0] pwm_fault_level;
    logic [1:0] pwm_reload_level;
    logic [1:0] converter_zero_cross_level;
    logic [1:0] converter_b_done_level;
    logic [1:0] converter_a_done_level;
    logic [1:0] interval_timer2_level;

    // Fields sit in register order.
    assign first_timer_ch3_level =
        prio_timers_a_q[ipf_pkg::FIRST_TIMER_CH3_LSB +: 2]; // [RULE_03]
    assign first_timer_ch2_level =
        prio_timers_a_q[ipf_pkg::FIRST_TIMER_CH2_LSB +: 2]; // [RULE_03]
    assign first_timer_ch1_level =
        prio_timers_a_q[ipf_pkg::FIRST_TIMER_CH1_LSB +: 2]; // [RULE_03]
    assign first_timer_ch0_level =
        prio_timers_a_q[ipf_pkg::FIRST_TIMER_CH0_LSB +: 2]; // [RULE_03]
    assign twowire_status_level =
        prio_timers_a_q[ipf_pkg::TWOWIRE_STATUS_LSB +: 2]; // [RULE_04]
    assign twowire_transmit_level =
        prio_timers_a_q[ipf_pkg::TWOWIRE_TRANSMIT_LSB +: 2]; // [RULE_04]
    assign twowire_receive_level =
        prio_timers_a_q[ipf_pkg::TWOWIRE_RECEIVE_LSB +: 2]; // [RULE_04]
    assign twowire_general_call_level =
        prio_timers_a_q[ipf_pkg::TWOWIRE_GENERAL_CALL_LSB +: 2]; // [RULE_04]

    assign interval_timer1_level =
        prio_interval_q[ipf_pkg::INTERVAL_TIMER1_LSB +: 2]; // [RULE_05]
    assign interval_timer0_level =
        prio_interval_q[ipf_pkg::INTERVAL_TIMER0_LSB +: 2]; // [RULE_05]
    assign second_comparator_level =
        prio_interval_q[ipf_pkg::SECOND_COMPARATOR_LSB +: 2]; // [RULE_06]
    assign first_comparator_level =
        prio_interval_q[ipf_pkg::FIRST_COMPARATOR_LSB +: 2]; // [RULE_06]
    assign second_timer_ch3_level =
        prio_interval_q[ipf_pkg::SECOND_TIMER_CH3_LSB +: 2]; // [RULE_07]
    assign second_timer_ch2_level =
        prio_interval_q[ipf_pkg::SECOND_TIMER_CH2_LSB +: 2]; // [RULE_07]
    assign second_timer_ch1_level =
        prio_interval_q[ipf_pkg::SECOND_TIMER_CH1_LSB +: 2]; // [RULE_07]
    assign second_timer_ch0_level =
        prio_interval_q[ipf_pkg::SECOND_TIMER_CH0_LSB +: 2]; // [RULE_07]

    assign pwm_fault_level =
        prio_pwm_conv_q[ipf_pkg::PWM_FAULT_LSB +: 2]; // [RULE_09]
    assign pwm_reload_level =
        prio_pwm_conv_q[ipf_pkg::PWM_RELOAD_LSB +: 2]; // [RULE_10]
    assign converter_zero_cross_level =
        prio_pwm_conv_q[ipf_pkg::CONVERTER_ZERO_CROSS_LSB +: 2]; // [RULE_11]
    assign converter_b_done_level =
        prio_pwm_conv_q[ipf_pkg::CONVERTER_B_DONE_LSB +: 2]; // [RULE_11]
    assign converter_a_done_level =
        prio_pwm_conv_q[ipf_pkg::CONVERTER_A_DONE_LSB +: 2]; // [RULE_11]
    assign interval_timer2_level =
        prio_pwm_conv_q[ipf_pkg::INTERVAL_TIMER2_LSB +: 2]; // [RULE_11]

    // ----------------------------------------------------------------
    // Level gating
    // ----------------------------------------------------------------
    // Source n owns bits 2n+1:2n; the order follows register then field position, except that the third register's bits 11:8 come before its bits 7:0.
    logic [2*ipf_pkg::NUM_SRC-1:0] all_fields;
    ipf_pkg::ipf_lvl_req_s gated;

    assign all_fields = {
        converter_zero_cross_level,
        converter_b_done_level,
        converter_a_done_level,
        interval_timer2_level,
        pwm_fault_level,
        pwm_reload_level,
        interval_timer1_level,
        interval_timer0_level,
        second_comparator_level,
        first_comparator_level,
        second_timer_ch3_level,
        second_timer_ch2_level,
        second_timer_ch1_level,
        second_timer_ch0_level,
        first_timer_ch3_level,
        first_timer_ch2_level,
        first_timer_ch1_level,
        first_timer_ch0_level,
        twowire_status_level,
        twowire_transmit_level,
        twowire_receive_level,
        twowire_general_call_level
    };

    ipf_level_gate #(
        .NSRC(ipf_pkg::NUM_SRC)
    ) u_gate (
        .fields(all_fields),
        .src_req(src_req),
        .lvl_req(gated)
    );

    // ----------------------------------------------------------------
    // Summary toward the core
    // ----------------------------------------------------------------
    logic any_l2;
    logic any_l1;
    logic any_l0;
    logic [1:0] top_level_d;

    // Level 2 outranks levels 1 and 0.
    assign any_l2 = |gated.lvl2;
    assign any_l1 = |gated.lvl1;
    assign any_l0 = |gated.lvl0;
    assign top_level_d = any_l2 ? ipf_pkg::LVL_2 :
                         any_l1 ? ipf_pkg::LVL_1 :
                         any_l0 ? ipf_pkg::LVL_0 : ipf_pkg::LVL_OFF; // [RULE_01]

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_req <= '0;
            core_top_level <= ipf_pkg::LVL_OFF;
            core_any_req <= 1'b0;
        end else begin
            core_req <= gated; // [RULE_12]
            core_top_level <= top_level_d;
            core_any_req <= any_l2 | any_l1 | any_l0; // [RULE_12]
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data holds until the next read.
    logic [NSRC-1:0] forwarded;
    logic [31:0] rd_mux;

    assign forwarded = core_req.lvl2 | core_req.lvl1 | core_req.lvl0;
    assign rd_mux =
        sel_timers_a ? {16'h0000, prio_timers_a_q} :
        sel_interval ? {16'h0000, prio_interval_q} :
        sel_pwm_conv ? {16'h0000, prio_pwm_conv_q} : // [RULE_08]
        sel_forwarded ? {10'h000, forwarded} :
        sel_top_level ? {30'h0000_0000, core_top_level} : ipf_pkg::READ_ZERO;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_readdata <= ipf_pkg::READ_ZERO;
        end else if (bus_take && bus.read) begin
            avs_readdata <= rd_mux;
        end
    end

endmodule

// ### tb/ipf_core_model.sv
// Purpose: Stand-in for the core that takes the ranked requests.
// Assumes: Requests are levels on clk_sys.
// Notes: Keeps the highest level offered since reset.
`timescale 1ns/1ns
module ipf_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Ranked requests
    input wire logic [1:0] core_top_level,
    input wire logic core_any_req,
    // Observation
    output logic [1:0] peak_level_q
);
    logic [1:0] peak_level_d;
    assign peak_level_d = (core_any_req && core_top_level > peak_level_q) ? core_top_level
                                                                           : peak_level_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            peak_level_q <= 2'h0;
        end else begin
            peak_level_q <= peak_level_d;
        end
    end
endmodule

// ### tb/ipf_prio_monitor.sv
// Purpose: Port checks on the priority field block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Attached by bind below the module.
`timescale 1ns/1ns
module ipf_prio_monitor #(
    parameter int unsigned NSRC = ipf_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic [ipf_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ipf_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Requests
    input wire logic [NSRC-1:0] src_req,
    input wire ipf_pkg::ipf_lvl_req_s core_req,
    input wire logic [1:0] core_top_level,
    input wire logic core_any_req
);
    wire [NSRC-1:0] fwd = core_req.lvl0 | core_req.lvl1 | core_req.lvl2;
    wire [1:0] top = (core_req.lvl2 != '0) ? 2'h3 : (core_req.lvl1 != '0) ? 2'h2 :
                     (core_req.lvl0 != '0) ? 2'h1 : 2'h0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    one_wait_a:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    wait_pulse_a:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a:
        assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    rsvd_zero_a:
        assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h06
                         |-> avs_readdata[15:12] == 4'h0 && avs_readdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");
    one_level_a:
        assert property (((core_req.lvl0 & core_req.lvl1) | (core_req.lvl0 & core_req.lvl2) |
                          (core_req.lvl1 & core_req.lvl2)) == '0)
        else $error("source shown on two levels");
    gate_src_a:
        assert property ((fwd & ~$past(src_req)) == '0)
        else $error("request forwarded without a pending source");
    top_level_a:
        assert property (core_top_level == top)
        else $error("top level disagrees with forwarded requests");
    any_req_a:
        assert property (core_any_req == (fwd != '0))
        else $error("any-request flag disagrees with forwarded requests");
    reset_clear_a:
        assert property (disable iff (1'b0) !rst_n |=> avs_waitrequest && core_req == '0 &&
                         !core_any_req && avs_readdata == ipf_pkg::READ_ZERO)
        else $error("outputs not cleared by reset");
    rdata_hold_a:
        assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    cover property (core_top_level == 2'h3);
    cover property (core_top_level == 2'h1);
    cover property (avs_write && !avs_waitrequest);
    cover property (avs_read && !avs_waitrequest);
endmodule

bind ipf_priority_regs ipf_prio_monitor #(.NSRC(NSRC)) u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_req(src_req), .core_req(core_req), .core_top_level(core_top_level),
    .core_any_req(core_any_req));

// ### tb/testbench.sv
// Purpose: Self-checking bench for the priority field registers.
// Assumes: Register index times four is the byte address.
// Notes: Table rows first, then refusal cases, then the reset case.
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [5:0] idx;
        logic [15:0] wdata;
        logic [21:0] src;
        logic [15:0] rd;
    } ipf_row_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [21:0] src_req = 22'h0;
    ipf_pkg::ipf_lvl_req_s core_req;
    logic [1:0] core_top_level;
    logic core_any_req;
    logic [1:0] peak_level_q;
    logic [15:0] regs [4:6];
    logic [31:0] rdata;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    ipf_row_s rows [6];

    ipf_priority_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .src_req(src_req), .core_req(core_req),
        .core_top_level(core_top_level), .core_any_req(core_any_req));
    ipf_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .core_top_level(core_top_level),
        .core_any_req(core_any_req), .peak_level_q(peak_level_q));

    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [65:0] got, input logic [65:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // Holds the access until waitrequest is sampled low, then releases it.
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                       input logic [1:0] be);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, wd};
        avs_byteenable <= {2'h0, be};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic apply(input logic [21:0] s);
        src_req <= s;
        repeat (2) @(posedge clk_sys);
    endtask

    function automatic logic [65:0] exp_core(input logic [21:0] s);
        logic [43:0] f;
        logic [65:0] r;
        f = {regs[6][7:0], regs[6][11:8], regs[5], regs[4]};
        r = '0;
        for (int n = 0; n < 22; n++) begin
            r[44+n] = s[n] && f[2*n+:2] == 2'h3;
            r[22+n] = s[n] && f[2*n+:2] == 2'h2;
            r[n] = s[n] && f[2*n+:2] == 2'h1;
        end
        return r;
    endfunction

    function automatic logic [1:0] exp_top(input logic [65:0] r);
        return (r[65:44] != '0) ? 2'h3 : (r[43:22] != '0) ? 2'h2 : (r[21:0] != '0) ? 2'h1 : 2'h0;
    endfunction

    initial begin
        regs[4] = 16'h0000;
        regs[5] = 16'h0000;
        regs[6] = 16'h0000;
        rows = '{'{6'h04, 16'hE4E4, 22'h3FFFFF, 16'hE4E4}, '{6'h05, 16'h1B1B, 22'h3FFFFF, 16'h1B1B},
                 '{6'h06, 16'h06E4, 22'h3FFFFF, 16'h06E4}, '{6'h04, 16'h0000, 22'h0000FF, 16'h0000},
                 '{6'h05, 16'hFFFF, 22'h00AA00, 16'hFFFF}, '{6'h06, 16'h0555, 22'h3C0000, 16'h0555}};
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // ----------------------------------------------------------------
        // Table rows
        // ----------------------------------------------------------------
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wdata, 2'h3);
            regs[rows[i].idx] = rows[i].rd;
            bus(1'b0, rows[i].idx, 16'h0000, 2'h3);
            check("readback", rdata, {16'h0000, rows[i].rd});
            apply(rows[i].src);
            check("core_req", core_req, exp_core(rows[i].src));
            check("top_level", core_top_level, exp_top(exp_core(rows[i].src)));
            check("any_req", core_any_req, exp_core(rows[i].src) != '0);
            $display("row %0d done", i);
        end
        check("peak_level", peak_level_q, 2'h3);
        // ----------------------------------------------------------------
        // Reserved bits, byte lanes, unmapped places, reset
        // ----------------------------------------------------------------
        bus(1'b1, 6'h06, 16'hFFFF, 2'h3);
        regs[6] = 16'h0FFF;
        bus(1'b0, 6'h06, 16'h0000, 2'h3);
        check("reserved", rdata, 32'h0000_0FFF);
        apply(22'h3F0000);
        check("pwm_conv", core_req, exp_core(22'h3F0000));
        bus(1'b0, 6'h10, 16'h0000, 2'h3);
        check("fwd_mask", rdata, {10'h000, 22'h3F0000});
        bus(1'b0, 6'h11, 16'h0000, 2'h3);
        check("top_read", rdata, 32'h0000_0003);
        bus(1'b1, 6'h04, 16'hABCD, 2'h2);
        bus(1'b0, 6'h04, 16'h0000, 2'h3);
        check("byte_lane", rdata, 32'h0000_AB00);
        bus(1'b1, 6'h07, 16'hFFFF, 2'h3);
        bus(1'b0, 6'h07, 16'h0000, 2'h3);
        check("unmapped", rdata, 32'h0000_0000);
        $display("refusal cases done");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int k = 4; k <= 6; k++) begin
            bus(1'b0, k[5:0], 16'h0000, 2'h3);
            check("reset_value", rdata, 32'h0000_0000);
        end
        apply(22'h3FFFFF);
        check("reset_gate", core_any_req, 1'b0);
        $display("reset case done");
        stop_test();
    end
endmodule
